// >>> hio_consts.vh
`ifndef HIO_CONSTS_VH
`define HIO_CONSTS_VH

// APB byte offsets; each register takes one aligned word.
`define HIO_ADDR_W 8
`define HIO_OFS_PORT_A 8'h00
`define HIO_OFS_PORT_B 8'h04
`define HIO_OFS_CTRL 8'h08

// Port modes held per port.
`define HIO_MODE_IN 2'h0
`define HIO_MODE_OUT 2'h1
`define HIO_MODE_BIDIR 2'h2
`define HIO_MODE_BIT 2'h3

// Control byte identification.
`define HIO_CTL_MODE_TAG 2'h3
`define HIO_CTL_IEN_TAG 4'h5
`define HIO_CTL_HSDIR_TAG 4'h9
`define HIO_CTL_HSVAL_TAG 4'hD

// Bit-programmable interrupt logic functions.
`define HIO_FN_AND 2'h0
`define HIO_FN_OR 2'h1
`define HIO_FN_NAND 2'h2
`define HIO_FN_NOR 2'h3

// Status byte bit positions.
`define HIO_ST_INT_A 0
`define HIO_ST_INT_B 1
`define HIO_ST_A_IN 2
`define HIO_ST_A_OUT 3

// Reset values.
`define HIO_RST_HS_DRIVE 4'h5
`define HIO_RST_BYTE 8'h00

`endif

// >>> hio_port.v
// Contract
// - Two ports, eight data plus ready/strobe.
// - Control bytes written set port configuration.
// - Normal mode: eight-bit input or output port.
// - Bidirectional A; B handshake steers outbound.
// - Bit mode: each line has own direction.
// - Bit mode: handshake lines become general I/O, except B's while A is bidirectional.
// - Strobes trigger interrupts except in bit mode.
// - Strobe fall sets request; access clears it.
// - Status shows bidirectional request direction.
// - Bit mode: function byte then mask byte.
// - Bit mode request is level, never latched.
// - Per-port interrupt enable; status bits 0,1.
// - Input strobe: ready low, capture, request.
// - Port read drives buffered data onto bus.
// - Port read clears request, reasserts ready.
// - Output write latches byte, raises ready.
// - Output strobe rise drops ready, fall requests.
// - Bit-mode write changes only output lines.
// - Bit-mode read: inputs live, outputs latched.
// - Clear puts both ports in input mode.
// - Mode byte: bits 7:6 mode, 4:3 port.
//
// The address map and the APB register port were chosen for this implementation.
`include "hio_consts.vh"
`default_nettype none

module hio_port (
   input wire CLK,
   input wire ARST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [`HIO_ADDR_W-1:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire [7:0] PA_IN,
   output reg [7:0] PA_OUT,
   output reg [7:0] PA_OE,
   input wire [7:0] PB_IN,
   output reg [7:0] PB_OUT,
   output reg [7:0] PB_OE,
   input wire [3:0] HS_IN,
   output reg [3:0] HS_OUT,
   output reg [3:0] HS_OE,
   output reg A_INT_N,
   output reg B_INT_N
);

   // Handshake line index: 0 A ready, 1 A strobe, 2 B ready, 3 B strobe.
   localparam SEQ_IDLE = 2'd0;
   localparam SEQ_DIR = 2'd1;
   localparam SEQ_FUNC = 2'd2;
   localparam SEQ_MASK = 2'd3;
   localparam DEC_A = 2'd0;
   localparam DEC_B = 2'd1;
   localparam DEC_CTRL = 2'd2;
   localparam DEC_NONE = 2'd3;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function [1:0] hio_dec;
      input [`HIO_ADDR_W-1:0] addr;
      begin
         case (addr)
            `HIO_OFS_PORT_A: hio_dec = DEC_A;
            `HIO_OFS_PORT_B: hio_dec = DEC_B;
            `HIO_OFS_CTRL: hio_dec = DEC_CTRL;
            default: hio_dec = DEC_NONE;
         endcase
      end
   endfunction

   function hio_logic;
      input [7:0] val;
      input [7:0] mask;
      input [1:0] fn;
      reg all_hi;
      reg any_hi;
      begin
         all_hi = &(val | ~mask);
         any_hi = |(val & mask);
         case (fn)
            `HIO_FN_AND: hio_logic = all_hi;
            `HIO_FN_OR: hio_logic = any_hi;
            `HIO_FN_NAND: hio_logic = ~all_hi;
            default: hio_logic = ~any_hi;
         endcase
      end
   endfunction

   // Output lines take the new bit, input lines keep the old latch.
   function [7:0] hio_merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] dir;
      begin
         hio_merge = (old_v & ~dir) | (new_v & dir);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   reg [7:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg;
   reg [3:0] hs_s1_reg, hs_s2_reg;
   reg a_stb_prev_reg, b_stb_prev_reg;

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pa_s1_reg <= `HIO_RST_BYTE;
         pa_s2_reg <= `HIO_RST_BYTE;
         pb_s1_reg <= `HIO_RST_BYTE;
         pb_s2_reg <= `HIO_RST_BYTE;
         hs_s1_reg <= 4'h0;
         hs_s2_reg <= 4'h0;
         a_stb_prev_reg <= 1'b0;
         b_stb_prev_reg <= 1'b0;
      end else begin
         pa_s1_reg <= PA_IN;
         pa_s2_reg <= pa_s1_reg;
         pb_s1_reg <= PB_IN;
         pb_s2_reg <= pb_s1_reg;
         hs_s1_reg <= HS_IN;
         hs_s2_reg <= hs_s1_reg;
         a_stb_prev_reg <= hs_s2_reg[1];
         b_stb_prev_reg <= hs_s2_reg[3];
      end
   end

   wire a_stb_rise = hs_s2_reg[1] & ~a_stb_prev_reg;
   wire a_stb_fall = ~hs_s2_reg[1] & a_stb_prev_reg;
   wire b_stb_rise = hs_s2_reg[3] & ~b_stb_prev_reg;
   wire b_stb_fall = ~hs_s2_reg[3] & b_stb_prev_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration and handshake state.

   reg [1:0] mode_a_reg, mode_b_reg;
   reg [7:0] dir_a_reg, dir_b_reg, mask_a_reg, mask_b_reg;
   reg [1:0] func_a_reg, func_b_reg;
   reg [1:0] ien_reg;
   reg [3:0] hs_dir_reg, hs_val_reg;
   reg [1:0] seq_reg, seq_sel_reg;
   reg [7:0] ina_reg, inb_reg, outa_reg, outb_reg;
   reg rdy_a_reg, rdy_b_reg;
   reg req_a_reg, req_ao_reg, req_b_reg;

   wire [1:0] dec = hio_dec(PADDR);
   wire acc = PSEL & PENABLE & PREADY;
   wire wr_a = acc & PWRITE & (dec == DEC_A);
   wire wr_b = acc & PWRITE & (dec == DEC_B);
   wire wr_c = acc & PWRITE & (dec == DEC_CTRL);
   wire rd_a = acc & ~PWRITE & (dec == DEC_A);
   wire rd_b = acc & ~PWRITE & (dec == DEC_B);
   wire [7:0] wd = PWDATA[7:0];
   wire sel_a = wd[3];
   wire sel_b = wd[4];
   wire is_mode = (wd[1:0] == `HIO_CTL_MODE_TAG);
   wire a_bidir = (mode_a_reg == `HIO_MODE_BIDIR);

   // Line values as seen on the pins in bit mode.
   wire [7:0] val_a = hio_merge(pa_s2_reg, outa_reg, dir_a_reg);
   wire [7:0] val_b = hio_merge(pb_s2_reg, outb_reg, dir_b_reg);
   wire lvl_a = hio_logic(val_a, mask_a_reg, func_a_reg);
   wire lvl_b = hio_logic(val_b, mask_b_reg, func_b_reg);
   wire int_a = (mode_a_reg == `HIO_MODE_BIT) ? lvl_a : (req_a_reg | req_ao_reg);
   wire int_b = (mode_b_reg == `HIO_MODE_BIT) ? lvl_b : req_b_reg;
   wire [7:0] status = {hs_s2_reg, req_ao_reg, req_a_reg, int_b, int_a};

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_a_reg <= `HIO_MODE_IN;
         mode_b_reg <= `HIO_MODE_IN;
         dir_a_reg <= `HIO_RST_BYTE;
         dir_b_reg <= `HIO_RST_BYTE;
         mask_a_reg <= `HIO_RST_BYTE;
         mask_b_reg <= `HIO_RST_BYTE;
         func_a_reg <= `HIO_FN_AND;
         func_b_reg <= `HIO_FN_AND;
         ien_reg <= 2'h0;
         hs_dir_reg <= 4'h0;
         hs_val_reg <= 4'h0;
         seq_reg <= SEQ_IDLE;
         seq_sel_reg <= 2'h0;
         ina_reg <= `HIO_RST_BYTE;
         inb_reg <= `HIO_RST_BYTE;
         outa_reg <= `HIO_RST_BYTE;
         outb_reg <= `HIO_RST_BYTE;
         rdy_a_reg <= 1'b1;
         rdy_b_reg <= 1'b1;
         req_a_reg <= 1'b0;
         req_ao_reg <= 1'b0;
         req_b_reg <= 1'b0;
      end else begin
         // Control bytes; a bit-mode byte opens a direction/function/mask run.
         if (wr_c) begin
            if (seq_reg != SEQ_IDLE) begin
               case (seq_reg)
                  SEQ_DIR: begin
                     if (seq_sel_reg[0]) dir_a_reg <= wd;
                     if (seq_sel_reg[1]) dir_b_reg <= wd;
                     seq_reg <= SEQ_FUNC;
                  end
                  SEQ_FUNC: begin
                     if (seq_sel_reg[0]) func_a_reg <= wd[6:5];
                     if (seq_sel_reg[1]) func_b_reg <= wd[6:5];
                     seq_reg <= SEQ_MASK;
                  end
                  default: begin
                     if (seq_sel_reg[0]) mask_a_reg <= wd;
                     if (seq_sel_reg[1]) mask_b_reg <= wd;
                     seq_reg <= SEQ_IDLE;
                  end
               endcase
            end else if (is_mode) begin
               if (sel_a) begin
                  mode_a_reg <= wd[7:6];
                  rdy_a_reg <= (wd[7:6] != `HIO_MODE_OUT);
                  req_a_reg <= 1'b0;
                  req_ao_reg <= 1'b0;
                  if (wd[7:6] == `HIO_MODE_BIDIR) begin
                     rdy_b_reg <= 1'b0;
                  end
               end
               if (sel_b && wd[7:6] != `HIO_MODE_BIDIR) begin
                  mode_b_reg <= wd[7:6];
                  req_b_reg <= 1'b0;
                  if (!a_bidir || sel_a) begin
                     rdy_b_reg <= (wd[7:6] == `HIO_MODE_IN);
                  end
               end
               if (wd[7:6] == `HIO_MODE_BIT) begin
                  seq_reg <= SEQ_DIR;
                  seq_sel_reg <= {sel_b, sel_a};
               end
            end else if (wd[3:0] == `HIO_CTL_IEN_TAG) begin
               if (wd[4]) ien_reg[0] <= wd[7];
               if (wd[5]) ien_reg[1] <= wd[7];
            end else if (wd[3:0] == `HIO_CTL_HSDIR_TAG) begin
               hs_dir_reg <= wd[7:4];
            end else if (wd[3:0] == `HIO_CTL_HSVAL_TAG) begin
               hs_val_reg <= wd[7:4];
            end
         end
         // Port A. Clears come first so that a strobe in the same cycle wins.
         case (mode_a_reg)
            `HIO_MODE_IN, `HIO_MODE_BIDIR: begin
               if (rd_a) begin
                  req_a_reg <= 1'b0;
                  rdy_a_reg <= 1'b1;
               end
               if (a_stb_rise) begin
                  rdy_a_reg <= 1'b0;
                  ina_reg <= pa_s2_reg;
               end
               if (a_stb_fall) req_a_reg <= 1'b1;
               if (a_bidir) begin
                  if (wr_a) begin
                     outa_reg <= wd;
                     rdy_b_reg <= 1'b1;
                     req_ao_reg <= 1'b0;
                  end
                  if (b_stb_rise) rdy_b_reg <= 1'b0;
                  if (b_stb_fall) req_ao_reg <= 1'b1;
               end
            end
            `HIO_MODE_OUT: begin
               if (wr_a) begin
                  outa_reg <= wd;
                  rdy_a_reg <= 1'b1;
                  req_a_reg <= 1'b0;
               end
               if (a_stb_rise) rdy_a_reg <= 1'b0;
               if (a_stb_fall) req_a_reg <= 1'b1;
            end
            default: begin
               if (wr_a) outa_reg <= hio_merge(outa_reg, wd, dir_a_reg);
            end
         endcase
         // Port B; its handshake belongs to port A while A is bidirectional.
         case (mode_b_reg)
            `HIO_MODE_IN: begin
               if (rd_b) req_b_reg <= 1'b0;
               if (rd_b && !a_bidir) rdy_b_reg <= 1'b1;
               if (b_stb_rise && !a_bidir) begin
                  rdy_b_reg <= 1'b0;
                  inb_reg <= pb_s2_reg;
               end
               if (b_stb_fall && !a_bidir) req_b_reg <= 1'b1;
            end
            `HIO_MODE_OUT: begin
               if (wr_b) begin
                  outb_reg <= wd;
                  req_b_reg <= 1'b0;
               end
               if (wr_b && !a_bidir) rdy_b_reg <= 1'b1;
               if (b_stb_rise && !a_bidir) rdy_b_reg <= 1'b0;
               if (b_stb_fall && !a_bidir) req_b_reg <= 1'b1;
            end
            default: begin
               if (wr_b) outb_reg <= hio_merge(outb_reg, wd, dir_b_reg);
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered pin drive and interrupt outputs.

   reg [7:0] pa_oe_next, pb_oe_next;
   reg [3:0] hs_oe_next, hs_out_next;

   always @* begin
      case (mode_a_reg)
         `HIO_MODE_OUT: pa_oe_next = 8'hFF;
         `HIO_MODE_BIDIR: pa_oe_next = {8{hs_s2_reg[3]}};
         `HIO_MODE_BIT: pa_oe_next = dir_a_reg;
         default: pa_oe_next = 8'h00;
      endcase
      case (mode_b_reg)
         `HIO_MODE_OUT: pb_oe_next = 8'hFF;
         `HIO_MODE_BIT: pb_oe_next = dir_b_reg;
         default: pb_oe_next = 8'h00;
      endcase
      if (mode_a_reg == `HIO_MODE_BIT) begin
         hs_oe_next[1:0] = hs_dir_reg[1:0];
         hs_out_next[1:0] = hs_val_reg[1:0];
      end else begin
         hs_oe_next[1:0] = 2'b01;
         hs_out_next[1:0] = {1'b0, rdy_a_reg};
      end
      if (mode_b_reg == `HIO_MODE_BIT && !a_bidir) begin
         hs_oe_next[3:2] = hs_dir_reg[3:2];
         hs_out_next[3:2] = hs_val_reg[3:2];
      end else begin
         hs_oe_next[3:2] = 2'b01;
         hs_out_next[3:2] = {1'b0, rdy_b_reg};
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PA_OUT <= `HIO_RST_BYTE;
         PA_OE <= `HIO_RST_BYTE;
         PB_OUT <= `HIO_RST_BYTE;
         PB_OE <= `HIO_RST_BYTE;
         HS_OUT <= `HIO_RST_HS_DRIVE;
         HS_OE <= `HIO_RST_HS_DRIVE;
         A_INT_N <= 1'b1;
         B_INT_N <= 1'b1;
      end else begin
         PA_OUT <= outa_reg;
         PA_OE <= pa_oe_next;
         PB_OUT <= outb_reg;
         PB_OE <= pb_oe_next;
         HS_OUT <= hs_out_next;
         HS_OE <= hs_oe_next;
         A_INT_N <= ~(ien_reg[0] & int_a);
         B_INT_N <= ~(ien_reg[1] & int_b);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, read data prepared in the setup cycle.

   reg [7:0] rd_byte;

   always @* begin
      case (dec)
         DEC_A: rd_byte = (mode_a_reg == `HIO_MODE_BIT) ? val_a : ina_reg;
         DEC_B: rd_byte = (mode_b_reg == `HIO_MODE_BIT) ? val_b : inb_reg;
         DEC_CTRL: rd_byte = status;
         default: rd_byte = 8'h00;
      endcase
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & (dec == DEC_NONE);
         if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= {24'h00_0000, rd_byte};
         end
      end
   end

endmodule

`default_nettype wire

// >>> hio_nothing_else.v
`default_nettype none
`default_nettype wire

// >>> hio_port_props.sv
`include "hio_consts.vh"
`default_nettype none
module hio_port_chk (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`HIO_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [7:0] PA_OUT,
   input wire logic [7:0] PB_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   wire logic setup;
   wire logic mapped;
   wire logic wa;
   wire logic wb;
   assign setup = PSEL && !PENABLE;
   assign mapped = PADDR == `HIO_OFS_PORT_A || PADDR == `HIO_OFS_PORT_B
      || PADDR == `HIO_OFS_CTRL;
   assign wa = PSEL && PENABLE && PREADY && PWRITE && PADDR == `HIO_OFS_PORT_A;
   assign wb = PSEL && PENABLE && PREADY && PWRITE && PADDR == `HIO_OFS_PORT_B;
   ////////////////////////////////////////
   a_ready_after_setup: assert property (setup |=> PREADY)
      else $error("no PREADY after setup");
   a_ready_cause: assert property (PREADY |-> $past(setup))
      else $error("PREADY without setup");
   a_err_unmapped: assert property (PREADY && !mapped |-> PSLVERR)
      else $error("unmapped access not refused");
   a_err_only_bad: assert property (PSLVERR |-> PREADY && !mapped)
      else $error("PSLVERR on a mapped access");
   a_rdata_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_rdata_hold: assert property (!(setup && !PWRITE) |=> $stable(PRDATA))
      else $error("read data moved without a read");
   a_pa_by_write: assert property ($changed(PA_OUT) |-> $past(wa) || $past(wa, 2))
      else $error("port A output moved without a write");
   a_pb_by_write: assert property ($changed(PB_OUT) |-> $past(wb) || $past(wb, 2))
      else $error("port B output moved without a write");
endmodule
bind hio_port hio_port_chk u_hio_port_chk (
   .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PA_OUT(PA_OUT), .PB_OUT(PB_OUT)
);
`default_nettype wire

// >>> hio_periph.sv
`default_nettype none
module hio_periph (
   input wire logic clk,
   output logic [7:0] pa_drv,
   output logic [7:0] pb_drv,
   output logic [3:0] hs_drv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pa_drv = 8'h00;
      pb_drv = 8'h00;
      hs_drv = 4'h0;
   end
   // Data settles well before the strobe or read that uses it.
   task automatic put(input int port, input logic [7:0] d);
      @(posedge clk);
      if (port == 0) begin
         pa_drv <= d;
      end else begin
         pb_drv <= d;
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic hs(input int idx, input logic v);
      @(posedge clk);
      hs_drv[idx] <= v;
      repeat (6) @(posedge clk);
   endtask
   // A whole strobe pulse, also the dummy strobe that opens output.
   task automatic strobe(input int idx);
      hs(idx, 1'h1);
      hs(idx, 1'h0);
   endtask
endmodule
`default_nettype wire

// >>> programmable_handshake_io_port_tb_top.sv
`include "hio_consts.vh"
`default_nettype none
module programmable_handshake_io_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ofs_a = `HIO_OFS_PORT_A;
   localparam logic [7:0] ofs_b = `HIO_OFS_PORT_B;
   localparam logic [7:0] ofs_c = `HIO_OFS_CTRL;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] q;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, a_int_n, b_int_n;
   wire logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pa_drv, pb_drv, pa_pin, pb_pin;
   wire logic [3:0] hs_out, hs_oe, hs_drv, hs_pin;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] vals [2] = '{8'h3C, 8'hFF};
   logic [7:0] bits [3] = '{8'h00, 8'hF0, 8'h50};
   // A line driven by the device shows its value, otherwise the peripheral's.
   assign pa_pin = (pa_oe & pa_out) | (~pa_oe & pa_drv);
   assign pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_drv);
   assign hs_pin = (hs_oe & hs_out) | (~hs_oe & hs_drv);
   initial begin
      forever #50 clk = ~clk;
   end
   hio_port u_hio_port (
      .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PA_IN(pa_pin), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_pin), .PB_OUT(pb_out),
      .PB_OE(pb_oe), .HS_IN(hs_pin), .HS_OUT(hs_out), .HS_OE(hs_oe),
      .A_INT_N(a_int_n), .B_INT_N(b_int_n)
   );
   hio_periph u_hio_periph (.clk(clk), .pa_drv(pa_drv), .pb_drv(pb_drv), .hs_drv(hs_drv));
   ////////////////////////////////////////
   task automatic summarize();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic xe);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      // Only the bench timeout ends a wait for the slave's answer.
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      q = prdata;
      chk(pslverr, xe);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch++;
         summarize();
      end
   end
   ////////////////////////////////////////
   initial begin
      logic [2:0] fn;
      logic c;
      repeat (3) @(posedge clk);
      arst_n <= 1'h1;
      chk({hs_oe, hs_out, a_int_n, b_int_n}, 10'h157);
      apb(1'h0, 8'h0C, 8'h00, 1'h1);
      chk(q, 32'h0000_0000);
      apb(1'h1, 8'h10, 8'hFF, 1'h1);
      apb(1'h1, ofs_c, 8'hB5, 1'h0);
      foreach (vals[i]) begin
         u_hio_periph.put(0, vals[i]);
         u_hio_periph.strobe(1);
         apb(1'h0, ofs_c, 8'h00, 1'h0);
         chk({hs_out[0], a_int_n, q[1:0]}, 4'h1);
         apb(1'h0, ofs_a, 8'h00, 1'h0);
         chk(q, vals[i]);
         tick(2);
         chk({hs_out[0], a_int_n}, 2'h3);
      end
      apb(1'h1, ofs_c, 8'h15, 1'h0);
      u_hio_periph.put(0, 8'h81);
      u_hio_periph.strobe(1);
      apb(1'h0, ofs_c, 8'h00, 1'h0);
      chk({a_int_n, q[0]}, 2'h3);
      apb(1'h0, ofs_a, 8'h00, 1'h0);
      apb(1'h1, ofs_c, 8'h53, 1'h0);
      tick(2);
      chk({hs_out[2], b_int_n}, 2'h1);
      u_hio_periph.strobe(3);
      chk(b_int_n, 1'h0);
      apb(1'h1, ofs_b, 8'hA5, 1'h0);
      tick(2);
      chk({pb_oe, pb_out}, 16'hFFA5);
      chk({hs_out[2], b_int_n}, 2'h3);
      u_hio_periph.hs(3, 1'h1);
      chk(hs_out[2], 1'h0);
      u_hio_periph.hs(3, 1'h0);
      chk(b_int_n, 1'h0);
      for (fn = 3'h0; fn < 3'h4; fn++) begin
         apb(1'h1, ofs_c, 8'hD3, 1'h0);
         apb(1'h1, ofs_c, 8'h0F, 1'h0);
         apb(1'h1, ofs_c, {1'h0, fn[1:0], 5'h00}, 1'h0);
         apb(1'h1, ofs_c, 8'hF0, 1'h0);
         apb(1'h1, ofs_b, 8'hFF, 1'h0);
         foreach (bits[j]) begin
            u_hio_periph.put(1, bits[j]);
            tick(2);
            apb(1'h0, ofs_b, 8'h00, 1'h0);
            chk(q, {bits[j][7:4], 4'hF});
            c = fn[0] ? |bits[j][7:4] : &bits[j][7:4];
            chk(b_int_n, {~(c ^ fn[1])});
         end
      end
      chk(pb_oe, 8'h0F);
      u_hio_periph.strobe(3);
      chk(b_int_n, 1'h1);
      apb(1'h1, ofs_c, 8'hC9, 1'h0);
      apb(1'h1, ofs_c, 8'h4D, 1'h0);
      tick(2);
      chk({hs_oe[3:2], hs_out[3:2]}, 4'hD);
      apb(1'h1, ofs_c, 8'h09, 1'h0);
      apb(1'h1, ofs_c, 8'h8B, 1'h0);
      apb(1'h1, ofs_c, 8'hB5, 1'h0);
      apb(1'h1, ofs_a, 8'h77, 1'h0);
      tick(2);
      chk(hs_out[2], 1'h1);
      u_hio_periph.hs(3, 1'h1);
      chk({pa_oe, pa_out}, 16'hFF77);
      u_hio_periph.hs(3, 1'h0);
      chk(a_int_n, 1'h0);
      apb(1'h0, ofs_c, 8'h00, 1'h0);
      chk(q[3:0], 4'h9);
      u_hio_periph.put(0, 8'h5A);
      u_hio_periph.strobe(1);
      apb(1'h0, ofs_c, 8'h00, 1'h0);
      chk(q[3:2], 2'h3);
      apb(1'h0, ofs_a, 8'h00, 1'h0);
      chk(q, 32'h0000_005A);
      apb(1'h0, ofs_c, 8'h00, 1'h0);
      chk(q[3:2], 2'h2);
      // Port A leaves bidirectional mode for a plain output transfer.
      apb(1'h1, ofs_c, 8'h4B, 1'h0);
      tick(2);
      chk({hs_out[0], a_int_n}, 2'h1);
      u_hio_periph.strobe(1);
      chk(a_int_n, 1'h0);
      apb(1'h1, ofs_a, 8'h3C, 1'h0);
      tick(2);
      chk({pa_oe, pa_out}, 16'hFF3C);
      chk({hs_out[0], a_int_n}, 2'h3);
      u_hio_periph.hs(1, 1'h1);
      chk(hs_out[0], 1'h0);
      u_hio_periph.hs(1, 1'h0);
      chk(a_int_n, 1'h0);
      // Port B back to input mode with its own handshake.
      apb(1'h1, ofs_c, 8'h13, 1'h0);
      u_hio_periph.put(1, 8'hC3);
      u_hio_periph.strobe(3);
      chk({hs_out[2], b_int_n}, 2'h0);
      apb(1'h0, ofs_b, 8'h00, 1'h0);
      chk(q, 32'h0000_00C3);
      tick(2);
      chk({hs_out[2], b_int_n}, 2'h3);
      summarize();
   end
endmodule
`default_nettype wire
